// [rtl/link_state_regs_pkg.sv]
// Package: offsets, field layouts, codes and carrier types for the link/state register pair
`default_nettype none
package link_state_regs_pkg;
   localparam logic [11:0] LINK_STATUS_ADDR  = 12'h110;
   localparam logic [11:0] STATE_REQ_ADDR    = 12'h120;
   localparam logic [11:0] EVENT_REQ_ADDR    = 12'h220;
   localparam logic [11:0] SLAVE_CONFIG_ADDR = 12'h141;
   // Status field positions
   localparam int COMM_BIT_P0   = 9;
   localparam int LOOP_BIT_P0   = 8;
   localparam int LINK_BIT_P0   = 4;
   localparam int ENH_LINK_BIT  = 2;
   localparam int WDOG_BIT      = 1;
   localparam int HOST_OK_BIT   = 0;
   // Control field layout
   localparam int STATE_LSB     = 0;
   localparam int STATE_W       = 4;
   localparam int ERR_ACK_BIT   = 4;
   localparam logic [15:0] STATE_REQ_MASK  = 16'h001F;
   localparam logic [15:0] STATE_REQ_RESET = 16'h0001;
   localparam logic [15:0] STATUS_RESET    = 16'h0000;
   localparam int EMULATION_BIT = 0;
   localparam int LINK_EVENT_BIT = 0;
   localparam int STATE_EVENT_BIT = 0;
   typedef enum logic [3:0] {
      ST_INIT      = 4'h1,
      ST_PREOP     = 4'h2,
      ST_BOOTSTRAP = 4'h3,
      ST_SAFEOP    = 4'h4,
      ST_OP        = 4'h8
   } state_code_t;
   // One byte-wide access from either side
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } byte_access_t;
   // Per-port link indications
   typedef struct packed {
      logic [2:0] comm_ok;
      logic [2:0] loop_closed;
      logic [2:0] phy_link;
   } port_state_t;
endpackage : link_state_regs_pkg
`default_nettype wire

// [rtl/state_request_mailbox.sv]
// State transition request register with mailbox lock and emulation copy
`default_nettype none
module state_request_mailbox
   import link_state_regs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        emulation,
   input  wire logic        net_wr_lo,
   input  wire logic        net_wr_hi,
   input  wire logic [7:0]  wdata,
   input  wire logic        host_rd,
   output logic [15:0]      value,
   output logic             locked,
   output logic             accepted,
   output logic [15:0]      mirror,
   output logic             mirror_wr
);
   logic [15:0] value_q;
   logic [15:0] value_d;
   logic        locked_q;
   logic        locked_d;
   logic        wr_any;
   logic        take;

   assign wr_any  = net_wr_lo | net_wr_hi;
   // Emulation ignores the lock entirely
   assign take    = wr_any & (emulation | ~locked_q);
   assign value_d = !take ? value_q :
                    net_wr_lo ? {value_q[15:8], wdata} & STATE_REQ_MASK :
                    {wdata, value_q[7:0]} & STATE_REQ_MASK;
   // An accepted write wins over a host read in the same cycle; a write refused by the lock does not
   assign locked_d = (take & ~emulation) ? 1'b1 :
                     host_rd ? 1'b0 : locked_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         value_q  <= STATE_REQ_RESET;
         locked_q <= 1'b0;
      end else begin
         value_q  <= value_d;
         locked_q <= locked_d;
      end
   end

   assign value     = value_q;
   assign locked    = locked_q;
   assign accepted  = take;
   assign mirror    = value_d;
   assign mirror_wr = take & emulation;

   a_lock_holds: assert property (@(posedge clk) disable iff (rst)
      locked_q && !host_rd && !emulation && wr_any |=> $stable(value_q))
      else $error("locked request register changed");
   a_lock_release: assert property (@(posedge clk) disable iff (rst)
      host_rd && !(take && !emulation) |=> !locked_q)
      else $error("host read did not release lock");
endmodule : state_request_mailbox
`default_nettype wire

// [rtl/link_state_regs.sv]
// Link-layer status and state-request registers seen from network and host sides
`default_nettype none
// Notes on behaviour
// - Bits 13, 11, 9 show stable communication on ports 2, 1, 0.
// - Bits 12, 10, 8 show loop closed (1) or open (0) per port.
// - Bits 6, 5, 4 show physical link on ports 2, 1, 0.
// - Bit 2 enhanced link: zero until first config load, then frozen.
// - Bit 1 is 1 while host watchdog reloaded, 0 once expired.
// - Bit 0 is 1 only when config loaded and host port operational.
// - Network read of status clears the link status event bit.
// - Multi-byte registers place low byte at the lower address.
// - Control bits 3:0 request state; codes 1,2,3,4,8; reset 1h.
// - Control bit 4 acknowledges error indication; resets to 0.
// - Without emulation, network writes lock until host reads register.
// - After reset a network write is accepted without host read.
// - Host read of 0120h or 0121h releases the lock.
// - With emulation, writes always taken and copied to application status.
// - Host read of control clears application-control event, 0220h bit 0.
// - Emulation chosen by config bit 0 at 0141h.
module link_state_regs
   import link_state_regs_pkg::*;
(
   // Clock and reset
   input  wire logic                          SYS_CLK_IN,
   input  wire logic                          RST_IN,
   // Network side byte access
   input  wire link_state_regs_pkg::byte_access_t NET_ACC_IN,
   output logic [7:0]                         NET_RDATA_OUT,
   output logic                               NET_WR_REFUSED_OUT,
   // Host side byte access
   input  wire link_state_regs_pkg::byte_access_t HOST_ACC_IN,
   output logic [7:0]                         HOST_RDATA_OUT,
   // Port and core conditions from the pins
   input  wire link_state_regs_pkg::port_state_t  PORT_STATE_IN,
   input  wire logic                          WDOG_RELOADED_IN,
   input  wire logic                          HOST_OPERATIONAL_IN,
   input  wire logic                          CFG_LOAD_DONE_IN,
   input  wire logic                          CFG_LOAD_OK_IN,
   input  wire logic                          CFG_ENH_LINK_IN,
   input  wire logic [7:0]                    SLAVE_CONFIG_IN,
   // Events and application status
   output logic                               LINK_STATUS_EVENT_OUT,
   output logic                               STATE_REQ_EVENT_OUT,
   output logic [15:0]                        STATE_REQ_OUT,
   output logic [15:0]                        APP_STATUS_MIRROR_OUT,
   output logic                               APP_STATUS_MIRROR_WR_OUT,
   output logic                               PROCESS_ACCESS_OK_OUT
);
   import link_state_regs_pkg::*;

   // Pin inputs pass two flops before use
   port_state_t ports_s1_q;
   port_state_t ports_q;
   logic [5:0]  misc_s1_q;
   logic [5:0]  misc_q;
   logic [7:0]  cfg_s1_q;
   logic [7:0]  cfg_q;

   always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
         ports_s1_q <= '0;
         ports_q    <= '0;
         misc_s1_q  <= '0;
         misc_q     <= '0;
         cfg_s1_q   <= '0;
         cfg_q      <= '0;
      end else begin
         ports_s1_q <= PORT_STATE_IN;
         ports_q    <= ports_s1_q;
         misc_s1_q  <= {CFG_ENH_LINK_IN, CFG_LOAD_OK_IN, CFG_LOAD_DONE_IN,
                        HOST_OPERATIONAL_IN, WDOG_RELOADED_IN, 1'b0};
         misc_q     <= misc_s1_q;
         cfg_s1_q   <= SLAVE_CONFIG_IN;
         cfg_q      <= cfg_s1_q;
      end
   end

   wire logic wdog_ok   = misc_q[1];
   wire logic host_op   = misc_q[2];
   wire logic load_done = misc_q[3];
   wire logic load_ok   = misc_q[4];
   wire logic enh_cfg   = misc_q[5];
   wire logic emulation = cfg_q[EMULATION_BIT];

   // Register select for a 16-bit register, either byte; address bit 0 is ignored
   function automatic logic hits(input logic [11:0] a, input logic [11:0] base);
      hits = (a[11:1] == base[11:1]);
   endfunction : hits

   // Enhanced link value taken over at the first load only
   logic enh_q;
   logic enh_taken_q;
   logic load_ok_q;
   wire logic first_load = load_done & ~enh_taken_q;

   always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
         enh_q       <= 1'b0;
         enh_taken_q <= 1'b0;
         load_ok_q   <= 1'b0;
      end else begin
         if (first_load) begin
            enh_q       <= enh_cfg;
            enh_taken_q <= 1'b1;
         end
         if (load_done) begin
            load_ok_q <= load_ok;
         end
      end
   end

   // Status word assembled from live port state
   logic [15:0] status_w;
   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_port
         assign status_w[COMM_BIT_P0 + 2*p] = ports_q.comm_ok[p];
         assign status_w[LOOP_BIT_P0 + 2*p] = ports_q.loop_closed[p];
         assign status_w[LINK_BIT_P0 + p]   = ports_q.phy_link[p];
      end
   endgenerate
   assign status_w[15:14] = 2'b00;
   assign status_w[7]     = 1'b0;
   assign status_w[3]     = 1'b0;
   assign status_w[ENH_LINK_BIT] = enh_q;
   assign status_w[WDOG_BIT]     = wdog_ok;
   wire logic host_ok = load_ok_q & host_op;
   assign status_w[HOST_OK_BIT]  = host_ok;

   // Decode
   wire logic net_rd_status  = NET_ACC_IN.rd & hits(NET_ACC_IN.addr, LINK_STATUS_ADDR);
   wire logic net_rd_req     = NET_ACC_IN.rd & hits(NET_ACC_IN.addr, STATE_REQ_ADDR);
   wire logic net_wr_req     = NET_ACC_IN.wr & hits(NET_ACC_IN.addr, STATE_REQ_ADDR);
   wire logic net_wr_lo      = net_wr_req & ~NET_ACC_IN.addr[0];
   wire logic net_wr_hi      = net_wr_req & NET_ACC_IN.addr[0];
   wire logic host_rd_status = HOST_ACC_IN.rd & hits(HOST_ACC_IN.addr, LINK_STATUS_ADDR);
   wire logic host_rd_req    = HOST_ACC_IN.rd & hits(HOST_ACC_IN.addr, STATE_REQ_ADDR);
   wire logic host_rd_event  = HOST_ACC_IN.rd & (HOST_ACC_IN.addr == EVENT_REQ_ADDR);

   logic [15:0] req_value;
   logic        req_locked;
   logic        req_taken;
   logic [15:0] mirror_d;
   logic        mirror_wr_d;

   state_request_mailbox u_mailbox (
      .clk       (SYS_CLK_IN),
      .rst       (RST_IN),
      .emulation (emulation),
      .net_wr_lo (net_wr_lo),
      .net_wr_hi (net_wr_hi),
      .wdata     (NET_ACC_IN.wdata),
      .host_rd   (host_rd_req),
      .value     (req_value),
      .locked    (req_locked),
      .accepted  (req_taken),
      .mirror    (mirror_d),
      .mirror_wr (mirror_wr_d)
   );

   // Read data: odd address returns the high byte
   wire logic [7:0] net_rd_d  = net_rd_status ?
                                (NET_ACC_IN.addr[0] ? status_w[15:8] : status_w[7:0]) :
                                net_rd_req ?
                                (NET_ACC_IN.addr[0] ? req_value[15:8] : req_value[7:0]) :
                                8'h00;
   wire logic [7:0] host_rd_d = host_rd_status ?
                                (HOST_ACC_IN.addr[0] ? status_w[15:8] : status_w[7:0]) :
                                host_rd_req ?
                                (HOST_ACC_IN.addr[0] ? req_value[15:8] : req_value[7:0]) :
                                host_rd_event ? {7'h00, STATE_REQ_EVENT_OUT} :
                                8'h00;

   // Events: set wins over the clear in the same cycle
   logic [15:0] status_prev_q;
   wire logic status_changed = (status_w != status_prev_q);
   wire logic link_ev_d  = status_changed | (LINK_STATUS_EVENT_OUT & ~net_rd_status);
   wire logic state_ev_d = req_taken | (STATE_REQ_EVENT_OUT & ~host_rd_req);

   always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
         status_prev_q            <= STATUS_RESET;
         NET_RDATA_OUT            <= 8'h00;
         HOST_RDATA_OUT           <= 8'h00;
         NET_WR_REFUSED_OUT       <= 1'b0;
         LINK_STATUS_EVENT_OUT    <= 1'b0;
         STATE_REQ_EVENT_OUT      <= 1'b0;
         STATE_REQ_OUT            <= STATE_REQ_RESET;
         APP_STATUS_MIRROR_OUT    <= STATE_REQ_RESET;
         APP_STATUS_MIRROR_WR_OUT <= 1'b0;
         PROCESS_ACCESS_OK_OUT    <= 1'b0;
      end else begin
         status_prev_q            <= status_w;
         NET_RDATA_OUT            <= net_rd_d;
         HOST_RDATA_OUT           <= host_rd_d;
         NET_WR_REFUSED_OUT       <= net_wr_req & ~req_taken;
         LINK_STATUS_EVENT_OUT    <= link_ev_d;
         STATE_REQ_EVENT_OUT      <= state_ev_d;
         STATE_REQ_OUT            <= req_value;
         APP_STATUS_MIRROR_OUT    <= mirror_wr_d ? mirror_d : APP_STATUS_MIRROR_OUT;
         APP_STATUS_MIRROR_WR_OUT <= mirror_wr_d;
         PROCESS_ACCESS_OK_OUT    <= host_ok;
      end
   end

   a_link_ev_clear: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      net_rd_status && !status_changed |=> !LINK_STATUS_EVENT_OUT)
      else $error("status read left link event set");
   a_state_ev_clear: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      host_rd_req && !req_taken |=> !STATE_REQ_EVENT_OUT)
      else $error("host read left state event set");
   a_emul_accept: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      net_wr_req && emulation |=> APP_STATUS_MIRROR_WR_OUT ##1
      APP_STATUS_MIRROR_OUT == STATE_REQ_OUT)
      else $error("emulation write not mirrored");
   a_host_ok_gate: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      PROCESS_ACCESS_OK_OUT |-> $past(load_ok_q) && $past(host_op))
      else $error("process access granted without load");
   a_enh_frozen: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      enh_taken_q |=> $stable(enh_q))
      else $error("enhanced link bit changed after load");
   a_reserved_zero: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      STATE_REQ_OUT[15:5] == 11'h000)
      else $error("reserved control bits nonzero");
   a_refuse_locked: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      net_wr_req && req_locked && !emulation |=> NET_WR_REFUSED_OUT)
      else $error("locked write not refused");
   a_reset_writable: assert property (@(posedge SYS_CLK_IN)
      $fell(RST_IN) |-> !req_locked)
      else $error("mailbox locked after reset");
   a_comm_bit: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      status_w[13] == ports_q.comm_ok[2] && status_w[12] == ports_q.loop_closed[2])
      else $error("port 2 status bits misplaced");
   a_link_bit: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      status_w[6:4] == ports_q.phy_link && status_w[1] == wdog_ok)
      else $error("link or watchdog bit misplaced");
   // Event sources must raise their flag one cycle later
   a_link_ev_set: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      status_changed |=> LINK_STATUS_EVENT_OUT)
      else $error("status change did not raise link event");
   a_state_ev_set: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      req_taken |=> STATE_REQ_EVENT_OUT)
      else $error("accepted write did not raise state event");
   a_taken_not_refused: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      net_wr_req && req_taken |=> !NET_WR_REFUSED_OUT)
      else $error("accepted write reported as refused");
   a_req_out_follows: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      !req_taken |=> STATE_REQ_OUT == $past(req_value))
      else $error("request output lags internal value");
   // Before the first load the enhanced link bit must stay clear
   a_enh_zero_early: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      !enh_taken_q |-> !enh_q)
      else $error("enhanced link bit set before load");
   a_status_reserved: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      status_w[15:14] == 2'b00 && !status_w[7] && !status_w[3])
      else $error("reserved status bits nonzero");
   a_mirror_hold: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      !mirror_wr_d |=> $stable(APP_STATUS_MIRROR_OUT))
      else $error("application status copy changed without write");
   a_host_ok_follow: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
      load_ok_q && host_op |=> PROCESS_ACCESS_OK_OUT)
      else $error("process access not granted when ready");
endmodule : link_state_regs
`default_nettype wire

// [sim/access_model.sv]
// Network master and host processor model issuing byte accesses
`default_nettype none
module access_model
   import link_state_regs_pkg::*;
(
   // Clock
   input  wire logic                              clk,
   // Answers from the block
   input  wire logic [7:0]                        net_rdata,
   input  wire logic [7:0]                        host_rdata,
   input  wire logic                              net_refused,
   // Requests toward the block
   output var  link_state_regs_pkg::byte_access_t net_acc,
   output var  link_state_regs_pkg::byte_access_t host_acc
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      net_acc = '0;
      host_acc = '0;
   end

   // One access: held for one edge, answer taken just after that same edge
   task automatic xfer(input logic net, input logic wr, input logic [11:0] a,
                       input logic [7:0] d, output logic [7:0] q, output logic refd);
      byte_access_t acc;
      acc = '{rd: !wr, wr: wr, addr: a, wdata: d};
      @(posedge clk);
      #1;
      if (net) net_acc = acc;
      else host_acc = acc;
      @(posedge clk);
      #1;
      net_acc = '0;
      host_acc = '0;
      q = net ? net_rdata : host_rdata;
      refd = net_refused;
   endtask : xfer
endmodule : access_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the link status and state request registers
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import link_state_regs_pkg::*;

   logic         clk;
   logic         rst;
   byte_access_t net_acc;
   byte_access_t host_acc;
   logic [7:0]   net_rdata;
   logic [7:0]   host_rdata;
   logic [7:0]   slave_cfg;
   logic [7:0]   d8;
   logic [15:0]  q;
   logic [15:0]  state_req;
   logic [15:0]  mirror;
   logic         refused;
   logic         rf;
   logic         link_ev;
   logic         state_ev;
   logic         mirror_wr;
   logic         proc_ok;
   port_state_t  ports;
   logic         wdog;
   logic         host_op;
   logic         cfg_done;
   logic         cfg_ok;
   logic         cfg_enh;
   int           errors;
   int           n_compared;
   state_code_t  codes [5] = '{ST_INIT, ST_PREOP, ST_BOOTSTRAP, ST_SAFEOP, ST_OP};
   port_state_t  pats [3] = '{9'h1A5, 9'h0D3, 9'h16E};

   link_state_regs link_state_regs_inst (
      .SYS_CLK_IN(clk), .RST_IN(rst),
      .NET_ACC_IN(net_acc), .NET_RDATA_OUT(net_rdata), .NET_WR_REFUSED_OUT(refused),
      .HOST_ACC_IN(host_acc), .HOST_RDATA_OUT(host_rdata),
      .PORT_STATE_IN(ports), .WDOG_RELOADED_IN(wdog), .HOST_OPERATIONAL_IN(host_op),
      .CFG_LOAD_DONE_IN(cfg_done), .CFG_LOAD_OK_IN(cfg_ok), .CFG_ENH_LINK_IN(cfg_enh),
      .SLAVE_CONFIG_IN(slave_cfg), .LINK_STATUS_EVENT_OUT(link_ev),
      .STATE_REQ_EVENT_OUT(state_ev), .STATE_REQ_OUT(state_req),
      .APP_STATUS_MIRROR_OUT(mirror), .APP_STATUS_MIRROR_WR_OUT(mirror_wr),
      .PROCESS_ACCESS_OK_OUT(proc_ok)
   );

   access_model access_model_inst (
      .clk(clk), .net_rdata(net_rdata), .host_rdata(host_rdata),
      .net_refused(refused), .net_acc(net_acc), .host_acc(host_acc)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task automatic nrd(input logic [11:0] a);
      access_model_inst.xfer(1'b1, 1'b0, a, 8'h00, d8, rf);
      q = {8'h00, d8};
   endtask : nrd

   task automatic hrd(input logic [11:0] a);
      access_model_inst.xfer(1'b0, 1'b0, a, 8'h00, d8, rf);
      q = {8'h00, d8};
   endtask : hrd

   task automatic nwr(input logic [11:0] a, input logic [7:0] d);
      access_model_inst.xfer(1'b1, 1'b1, a, d, d8, rf);
   endtask : nwr

   // Expected status word from the pin levels driven here
   function automatic logic [15:0] status_exp(input logic enh, input logic ok);
      status_exp = {2'b00, ports.comm_ok[2], ports.loop_closed[2], ports.comm_ok[1],
                    ports.loop_closed[1], ports.comm_ok[0], ports.loop_closed[0], 1'b0,
                    ports.phy_link, 1'b0, enh, wdog, ok};
   endfunction : status_exp

   // Low byte first, so the byte order shows in the word
   task automatic chk_status(input logic [15:0] exp);
      logic [15:0] w;
      nrd(LINK_STATUS_ADDR);
      w[7:0] = q[7:0];
      nrd(LINK_STATUS_ADDR + 12'h001);
      w[15:8] = q[7:0];
      check("link_layer_status", w, exp);
   endtask : chk_status

   initial begin
      // Generous margin over the under two hundred cycles the sequence needs
      #(5 * 20000);
      errors++;
      summarize();
   end

   initial begin
      errors = 0;
      n_compared = 0;
      rst = 1'b1;
      ports = '0;
      wdog = 1'b0;
      host_op = 1'b0;
      cfg_done = 1'b0;
      cfg_ok = 1'b0;
      cfg_enh = 1'b0;
      slave_cfg = 8'h00;
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      nrd(STATE_REQ_ADDR);
      check("req_lo_reset", q, 16'h0001);
      nrd(STATE_REQ_ADDR + 12'h001);
      check("req_hi_reset", q, 16'h0000);
      chk_status(16'h0000);
      nrd(12'h112);
      check("unmapped", q, 16'h0000);
      nwr(STATE_REQ_ADDR, 8'h02);
      check("first_wr_refused", rf, 1'b0);
      check("state_event", state_ev, 1'b1);
      repeat (2) @(posedge clk);
      #1 check("state_req_out", state_req, 16'h0002);
      nwr(STATE_REQ_ADDR, 8'h04);
      check("locked_wr_refused", rf, 1'b1);
      nrd(STATE_REQ_ADDR);
      check("value_kept", q, 16'h0002);
      hrd(STATE_REQ_ADDR + 12'h001);
      check("host_rd_hi", q, 16'h0000);
      check("state_event_clr", state_ev, 1'b0);
      foreach (codes[i]) begin
         nwr(STATE_REQ_ADDR, {3'b000, i[0], codes[i]});
         check("code_wr_refused", rf, 1'b0);
         hrd(EVENT_REQ_ADDR);
         check("event_reg", q, 16'h0001);
         hrd(STATE_REQ_ADDR);
         check("code_value", q, {11'h000, i[0], codes[i]});
      end
      nwr(STATE_REQ_ADDR + 12'h001, 8'hFF);
      hrd(STATE_REQ_ADDR + 12'h001);
      check("reserved_hi", q, 16'h0000);
      // Emulation: no host read between the two writes
      slave_cfg = 8'h01;
      repeat (3) @(posedge clk);
      #1 nwr(STATE_REQ_ADDR, 8'h04);
      check("mirror_wr", mirror_wr, 1'b1);
      check("mirror_val", mirror, 16'h0004);
      nwr(STATE_REQ_ADDR, 8'h08);
      check("emul_refused", rf, 1'b0);
      check("mirror_val2", mirror, 16'h0008);
      for (int k = 0; k < 3; k++) begin
         ports = pats[k];
         wdog = k[0];
         repeat (3) @(posedge clk);
         #1 check("link_event", link_ev, 1'b1);
         chk_status(status_exp(1'b0, 1'b0));
         check("link_event_clr", link_ev, 1'b0);
      end
      cfg_enh = 1'b1;
      cfg_ok = 1'b1;
      host_op = 1'b1;
      cfg_done = 1'b1;
      repeat (4) @(posedge clk);
      #1 check("process_ok", proc_ok, 1'b1);
      chk_status(status_exp(1'b1, 1'b1));
      cfg_done = 1'b0;
      cfg_enh = 1'b0;
      repeat (4) @(posedge clk);
      #1 cfg_done = 1'b1;
      nwr(LINK_STATUS_ADDR, 8'hFF);
      repeat (4) @(posedge clk);
      #1 chk_status(status_exp(1'b1, 1'b1));
      host_op = 1'b0;
      repeat (4) @(posedge clk);
      #1 check("process_off", proc_ok, 1'b0);
      chk_status(status_exp(1'b1, 1'b0));
      summarize();
   end
endmodule : testbench
`default_nettype wire
